// ### rtl/hco_pkg.sv
/*
  Constants, register map and state encodings for the counter output control block.
  Assumes one 20 MHz clock and a host that reaches the registers over a plain word port.
*/
// Function
// - A compare point is active while its counter value is at least the point.
// - All four counters update the shared unit output pattern in crossing order.
// - Each compare point has an enable, clear after reset; disabled points change nothing.
// - An enabled point reached applies the set and clear masks of the counting direction.
// - Each preset or counter reset applies dedicated set and clear masks to the pattern.
// - When preset set and clear masks both select an output, it is cleared.
// - Drive is automatic after reset; a control bit of one selects manual drive.
// - In manual drive each physical output follows its host bit, bits zero and one.
// - On fault, outputs keep updating, freeze, or take a predefined pattern, by setting.
// - A counter is cleared by its software bit, an assigned input, or the index.
// - The software clear bit overrides other sources and acts at the next refresh.
// - Input and index clears act only while the software clear enable bit is one.
// - An input is a clear source only with function code 5, 6 or 11 to 14.
// - An input with function code 15 or 16 enables or disables clearing.
// - The index as clear source is enabled per counter by a configuration bit.
// - Each output has normal, delay, pulse or combined shaping, 1 to 9999 ms.
// - Normal shaping turns on at once; delay shaping turns on after the delay.
// - Pulse shaping turns on at once, holds for the duration, then turns off.
// - The output status word shows the shaped physical output state.
// - A pattern bit going off cancels timing and turns the output off at once.
// - A manually switched output turns on at once, without any shaping.
// - After a pulse the bit still counts as on; no new pulse until cleared.
// - In compare masks a zero leaves an output alone, a one sets or clears it.
// - A compare point with set and clear on one output in one direction clears it.
package hco_pkg;
  localparam int NCNT = 4;
  localparam int NCV = 8;
  localparam int CV_PER_CNT = 2;
  localparam int NOUT = 2;
  localparam int TMR_W = 14;
  localparam int CLK_HZ = 20_000_000;
  localparam int SHAPE_UNIT_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * SHAPE_UNIT_MS;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MAN = 8'h01;
  localparam logic [7:0] A_PREDEF = 8'h02;
  localparam logic [7:0] A_RSTCFG = 8'h03;
  localparam logic [7:0] A_DIFUNC = 8'h04;
  localparam logic [7:0] A_SHAPE = 8'h05;
  localparam logic [7:0] A_DLY0 = 8'h06;
  localparam logic [7:0] A_DUR0 = 8'h07;
  localparam logic [7:0] A_DLY1 = 8'h08;
  localparam logic [7:0] A_DUR1 = 8'h09;
  localparam logic [7:0] A_PRESET = 8'h0A;
  localparam logic [7:0] A_PRERST = 8'h0B;
  localparam logic [7:0] A_CVEN = 8'h0C;
  localparam logic [7:0] A_PATTERN = 8'h0D;
  localparam logic [7:0] A_OUTSTAT = 8'h0E;
  localparam logic [7:0] A_CVACT = 8'h0F;
  localparam logic [1:0] CV_REGION = 2'h1;
  localparam logic [2:0] F_VAL = 3'h0;
  localparam logic [2:0] F_SUP = 3'h1;
  localparam logic [2:0] F_RUP = 3'h2;
  localparam logic [2:0] F_SDN = 3'h3;
  localparam logic [2:0] F_RDN = 3'h4;

  localparam int CTRL_MAN_BIT = 0;
  localparam int CTRL_POL_LSB = 4;
  localparam int SWRST_LSB = 0;
  localparam int SWEN_LSB = 8;
  localparam int IDXEN_LSB = 16;
  localparam int DIF_STRIDE = 8;
  localparam int DIF_W = 5;

  localparam logic [4:0] FC_RST_A = 5'h05;
  localparam logic [4:0] FC_RST_B = 5'h06;
  localparam logic [4:0] FC_RST_LO = 5'h0B;
  localparam logic [4:0] FC_RST_HI = 5'h0E;
  localparam logic [4:0] FC_EN = 5'h0F;
  localparam logic [4:0] FC_DIS = 5'h10;

  localparam logic [1:0] POL_RUN = 2'h0;
  localparam logic [1:0] POL_FREEZE = 2'h1;
  localparam logic [1:0] POL_PREDEF = 2'h2;

  localparam logic [1:0] MODE_NORM = 2'h0;
  localparam logic [1:0] MODE_DELAY = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  typedef enum logic [4:0] {
    SH_OFF = 5'h01,
    SH_WAIT = 5'h02,
    SH_ON = 5'h04,
    SH_PULSE = 5'h08,
    SH_SPENT = 5'h10
  } hco_shape_t;
endpackage

// ### rtl/hco_output_ctrl.sv
/*
  Output control of a four-counter counting unit: compare points, unit output pattern,
  fault policy, counter clear sources and output pulse shaping for two physical outputs.
  Assumes counter values, presets, refresh and fault levels come from logic on clk;
  digital inputs and index signals are asynchronous pins.
*/
module hco_output_ctrl #(
  parameter int TICK_CYCLES = hco_pkg::MS_CYCLES
) (
  // Clock, reset, enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Counting core.
  input wire logic [hco_pkg::NCNT-1:0][31:0] counter_value,
  input wire logic [hco_pkg::NCNT-1:0] preset_evt,
  output logic [hco_pkg::NCNT-1:0] counter_clear,
  // Host refresh and fault conditions.
  input wire logic io_refresh,
  input wire logic host_prog_mode,
  input wire logic host_bus_err,
  input wire logic count_fault,
  // Field pins.
  input wire logic [hco_pkg::NCNT-1:0] digital_in,
  input wire logic [hco_pkg::NCNT-1:0] index_in,
  output logic physical_output_zero,
  output logic physical_output_one
);
  localparam int NCV = hco_pkg::NCV;
  localparam int NCNT = hco_pkg::NCNT;
  localparam int NOUT = hco_pkg::NOUT;
  localparam int TW = hco_pkg::TMR_W;

  logic [31:0] cv_val [NCV];
  logic [31:0] cv_sup [NCV];
  logic [31:0] cv_rup [NCV];
  logic [31:0] cv_sdn [NCV];
  logic [31:0] cv_rdn [NCV];
  logic [NCV-1:0] cv_en;
  logic [NCV-1:0] cv_act;
  logic [NCV-1:0] cv_ge;
  logic [NCV-1:0] cv_rise;
  logic [NCV-1:0] cv_fall;
  logic primed;
  logic manual;
  logic [1:0] policy;
  logic [NOUT-1:0] man_bits;
  logic [31:0] predef;
  logic [NCNT-1:0] sw_rst;
  logic [NCNT-1:0] sw_en;
  logic [NCNT-1:0] idx_en;
  logic [31:0] difunc;
  logic [2*NOUT-1:0] shape;
  logic [TW-1:0] dly [NOUT];
  logic [TW-1:0] dur [NOUT];
  logic [31:0] pre_set;
  logic [31:0] pre_rst;
  logic [31:0] pattern;
  logic [31:0] next_pattern;
  logic [31:0] applied;
  logic [31:0] applied_prev;
  logic [NOUT-1:0] phys;
  logic [31:0] rd_val;
  logic cv_wr;
  logic [2:0] cv_idx;
  logic fault;
  logic [31:0] tick_cnt;
  logic tick;
  logic [NCNT-1:0] di_s1, di_s2, di_s3;
  logic [NCNT-1:0] ix_s1, ix_s2, ix_s3;
  logic [NCNT-1:0] next_clear;
  hco_pkg::hco_shape_t sh_st [NOUT];
  hco_pkg::hco_shape_t next_st [NOUT];
  logic [TW-1:0] tmr [NOUT];

  assign cv_wr = reg_wr && reg_addr[7:6] == hco_pkg::CV_REGION;
  assign cv_idx = reg_addr[5:3];
  assign fault = host_prog_mode || host_bus_err || count_fault;
  assign physical_output_zero = phys[0];
  assign physical_output_one = phys[1];

  // Compare point table; plain storage, so it carries no reset.
  always_ff @(posedge clk) begin
    if (ce && cv_wr) begin
      case (reg_addr[2:0])
        hco_pkg::F_VAL: cv_val[cv_idx] <= reg_wdata;
        hco_pkg::F_SUP: cv_sup[cv_idx] <= reg_wdata;
        hco_pkg::F_RUP: cv_rup[cv_idx] <= reg_wdata;
        hco_pkg::F_SDN: cv_sdn[cv_idx] <= reg_wdata;
        hco_pkg::F_RDN: cv_rdn[cv_idx] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Configuration registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      manual <= 1'b0;
      policy <= hco_pkg::POL_RUN;
      man_bits <= '0;
      predef <= 32'h0000_0000;
      sw_en <= '0;
      idx_en <= '0;
      difunc <= 32'h0000_0000;
      shape <= '0;
      pre_set <= 32'h0000_0000;
      pre_rst <= 32'h0000_0000;
      cv_en <= '0;
      for (int k = 0; k < NOUT; k++) begin
        dly[k] <= '0;
        dur[k] <= '0;
      end
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        hco_pkg::A_CTRL: begin
          manual <= reg_wdata[hco_pkg::CTRL_MAN_BIT];
          policy <= reg_wdata[hco_pkg::CTRL_POL_LSB +: 2];
        end
        hco_pkg::A_MAN: man_bits <= reg_wdata[NOUT-1:0];
        hco_pkg::A_PREDEF: predef <= reg_wdata;
        hco_pkg::A_RSTCFG: begin
          sw_en <= reg_wdata[hco_pkg::SWEN_LSB +: NCNT];
          idx_en <= reg_wdata[hco_pkg::IDXEN_LSB +: NCNT];
        end
        hco_pkg::A_DIFUNC: difunc <= reg_wdata;
        hco_pkg::A_SHAPE: shape <= reg_wdata[2*NOUT-1:0];
        hco_pkg::A_DLY0: dly[0] <= reg_wdata[TW-1:0];
        hco_pkg::A_DUR0: dur[0] <= reg_wdata[TW-1:0];
        hco_pkg::A_DLY1: dly[1] <= reg_wdata[TW-1:0];
        hco_pkg::A_DUR1: dur[1] <= reg_wdata[TW-1:0];
        hco_pkg::A_PRESET: pre_set <= reg_wdata;
        hco_pkg::A_PRERST: pre_rst <= reg_wdata;
        hco_pkg::A_CVEN: cv_en <= reg_wdata[NCV-1:0];
        default: ;
      endcase
    end
  end

  // A host write in the refresh cycle wins over the self-clear, so no request is lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_rst <= '0;
    end else if (ce) begin
      if (reg_wr && reg_addr == hco_pkg::A_RSTCFG) begin
        sw_rst <= reg_wdata[hco_pkg::SWRST_LSB +: NCNT];
      end else if (io_refresh) begin
        sw_rst <= '0;
      end
    end
  end

  // Compare flags. The first enabled cycle after reset only loads them, so a counter
  // already above a point does not fake a crossing.
  always_comb begin
    for (int i = 0; i < NCV; i++) begin
      cv_ge[i] = $signed(counter_value[i / hco_pkg::CV_PER_CNT]) >= $signed(cv_val[i]);
    end
  end
  assign cv_rise = primed ? (cv_ge & ~cv_act) : '0;
  assign cv_fall = primed ? (~cv_ge & cv_act) : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cv_act <= '0;
      primed <= 1'b0;
    end else if (ce) begin
      cv_act <= cv_ge;
      primed <= 1'b1;
    end
  end

  // Crossings in one cycle are applied in point order, then preset and clear events.
  always_comb begin
    next_pattern = pattern;
    for (int i = 0; i < NCV; i++) begin
      if (cv_en[i] && cv_rise[i]) begin
        next_pattern = (next_pattern | cv_sup[i]) & ~cv_rup[i];
      end else if (cv_en[i] && cv_fall[i]) begin
        next_pattern = (next_pattern | cv_sdn[i]) & ~cv_rdn[i];
      end
    end
    if (|preset_evt || |counter_clear) begin
      next_pattern = (next_pattern | pre_set) & ~pre_rst;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pattern <= 32'h0000_0000;
    end else if (ce) begin
      pattern <= next_pattern;
    end
  end

  // Fault policy: the pattern keeps evolving underneath, only what reaches the pins changes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      applied <= 32'h0000_0000;
      applied_prev <= 32'h0000_0000;
    end else if (ce) begin
      applied_prev <= applied;
      if (!fault || policy == hco_pkg::POL_RUN) begin
        applied <= next_pattern;
      end else if (policy == hco_pkg::POL_PREDEF) begin
        applied <= predef;
      end else if (policy != hco_pkg::POL_FREEZE) begin
        applied <= next_pattern;
      end
    end
  end

  // Pin synchronisers; only the second stage and later are looked at.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      di_s1 <= '0;
      di_s2 <= '0;
      di_s3 <= '0;
      ix_s1 <= '0;
      ix_s2 <= '0;
      ix_s3 <= '0;
    end else if (ce) begin
      di_s1 <= digital_in;
      di_s2 <= di_s1;
      di_s3 <= di_s2;
      ix_s1 <= index_in;
      ix_s2 <= ix_s1;
      ix_s3 <= ix_s2;
    end
  end

  always_comb begin
    for (int c = 0; c < NCNT; c++) begin
      logic [4:0] fc;
      logic di_src;
      logic di_gate;
      logic hw_req;
      fc = difunc[c*hco_pkg::DIF_STRIDE +: hco_pkg::DIF_W];
      di_src = fc == hco_pkg::FC_RST_A || fc == hco_pkg::FC_RST_B ||
               (fc >= hco_pkg::FC_RST_LO && fc <= hco_pkg::FC_RST_HI);
      di_gate = fc == hco_pkg::FC_EN ? di_s2[c] :
                fc == hco_pkg::FC_DIS ? !di_s2[c] : 1'b1;
      hw_req = (di_src && di_s2[c] && !di_s3[c]) ||
               (idx_en[c] && ix_s2[c] && !ix_s3[c]);
      next_clear[c] = (io_refresh && sw_rst[c]) || (sw_en[c] && di_gate && hw_req);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_clear <= '0;
    end else if (ce) begin
      counter_clear <= next_clear;
    end
  end

  // Shared millisecond tick; timers count one extra tick so no delay comes out short.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= tick_cnt == 32'(TICK_CYCLES - 1);
      tick_cnt <= tick_cnt == 32'(TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  always_comb begin
    for (int k = 0; k < NOUT; k++) begin
      logic [1:0] md;
      md = shape[2*k +: 2];
      next_st[k] = sh_st[k];
      if (!applied[k]) begin
        next_st[k] = hco_pkg::SH_OFF;
      end else begin
        unique case (sh_st[k])
          hco_pkg::SH_OFF: begin
            if (!applied_prev[k]) begin
              unique case (md)
                hco_pkg::MODE_NORM: next_st[k] = hco_pkg::SH_ON;
                hco_pkg::MODE_PULSE: next_st[k] = hco_pkg::SH_PULSE;
                default: next_st[k] = hco_pkg::SH_WAIT;
              endcase
            end
          end
          hco_pkg::SH_WAIT: begin
            if (tick && tmr[k] == '0) begin
              next_st[k] = md == hco_pkg::MODE_BOTH ? hco_pkg::SH_PULSE : hco_pkg::SH_ON;
            end
          end
          hco_pkg::SH_PULSE: begin
            if (tick && tmr[k] == '0) begin
              next_st[k] = hco_pkg::SH_SPENT;
            end
          end
          hco_pkg::SH_ON: next_st[k] = hco_pkg::SH_ON;
          hco_pkg::SH_SPENT: next_st[k] = hco_pkg::SH_SPENT;
          default: next_st[k] = hco_pkg::SH_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NOUT; k++) begin
        sh_st[k] <= hco_pkg::SH_OFF;
        tmr[k] <= '0;
      end
    end else if (ce) begin
      for (int k = 0; k < NOUT; k++) begin
        sh_st[k] <= next_st[k];
        if (next_st[k] == hco_pkg::SH_WAIT && sh_st[k] != hco_pkg::SH_WAIT) begin
          tmr[k] <= dly[k];
        end else if (next_st[k] == hco_pkg::SH_PULSE && sh_st[k] != hco_pkg::SH_PULSE) begin
          tmr[k] <= dur[k];
        end else if (tick && tmr[k] != '0) begin
          tmr[k] <= tmr[k] - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phys <= '0;
    end else if (ce) begin
      for (int k = 0; k < NOUT; k++) begin
        if (manual) begin
          phys[k] <= man_bits[k];
        end else begin
          phys[k] <= next_st[k] == hco_pkg::SH_ON || next_st[k] == hco_pkg::SH_PULSE;
        end
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr[7:6] == hco_pkg::CV_REGION) begin
      case (reg_addr[2:0])
        hco_pkg::F_VAL: rd_val = cv_val[cv_idx];
        hco_pkg::F_SUP: rd_val = cv_sup[cv_idx];
        hco_pkg::F_RUP: rd_val = cv_rup[cv_idx];
        hco_pkg::F_SDN: rd_val = cv_sdn[cv_idx];
        hco_pkg::F_RDN: rd_val = cv_rdn[cv_idx];
        default: rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (reg_addr)
        hco_pkg::A_CTRL: rd_val = {26'h000_0000, policy, 3'h0, manual};
        hco_pkg::A_MAN: rd_val = {30'h0000_0000, man_bits};
        hco_pkg::A_PREDEF: rd_val = predef;
        hco_pkg::A_RSTCFG: rd_val = {12'h000, idx_en, 4'h0, sw_en, 4'h0, sw_rst};
        hco_pkg::A_DIFUNC: rd_val = difunc;
        hco_pkg::A_SHAPE: rd_val = {28'h000_0000, shape};
        hco_pkg::A_DLY0: rd_val = {18'h0_0000, dly[0]};
        hco_pkg::A_DUR0: rd_val = {18'h0_0000, dur[0]};
        hco_pkg::A_DLY1: rd_val = {18'h0_0000, dly[1]};
        hco_pkg::A_DUR1: rd_val = {18'h0_0000, dur[1]};
        hco_pkg::A_PRESET: rd_val = pre_set;
        hco_pkg::A_PRERST: rd_val = pre_rst;
        hco_pkg::A_CVEN: rd_val = {24'h00_0000, cv_en};
        hco_pkg::A_PATTERN: rd_val = pattern;
        hco_pkg::A_OUTSTAT: rd_val = {30'h0000_0000, phys};
        hco_pkg::A_CVACT: rd_val = {24'h00_0000, cv_act};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_act_flag;
    ce && cv_en[0] |=> cv_act[0] == ($signed($past(counter_value[0])) >= $signed($past(cv_val[0])));
  endproperty
  a_act_flag: assert property (p_act_flag) else $error("compare flag wrong");

  property p_quiet_hold;
    ce && ~|(cv_en & (cv_rise | cv_fall)) && !(|preset_evt) && !(|counter_clear)
      |=> pattern == $past(pattern);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("pattern moved");

  property p_cv_clear;
    ce && cv_en[0] && cv_rise[0] && (cv_rise | cv_fall) == 8'h01 && !(|preset_evt)
      && !(|counter_clear) |=> (pattern & $past(cv_rup[0])) == 32'h0000_0000;
  endproperty
  a_cv_clear: assert property (p_cv_clear) else $error("clear mask ignored");

  property p_cv_set;
    ce && cv_en[0] && cv_rise[0] && (cv_rise | cv_fall) == 8'h01 && !(|preset_evt)
      && !(|counter_clear) |=> ((pattern | $past(cv_rup[0])) & $past(cv_sup[0])) == $past(cv_sup[0]);
  endproperty
  a_cv_set: assert property (p_cv_set) else $error("set mask ignored");

  property p_pre_clear;
    ce && (|counter_clear) && ~|(cv_en & (cv_rise | cv_fall))
      |=> (pattern & $past(pre_rst)) == 32'h0000_0000;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("preset clear lost");

  property p_manual;
    ce && manual |=> phys == $past(man_bits);
  endproperty
  a_manual: assert property (p_manual) else $error("manual drive wrong");

  property p_off_at_once;
    ce && !manual && !applied[0] |=> !phys[0] && sh_st[0] == hco_pkg::SH_OFF;
  endproperty
  a_off_at_once: assert property (p_off_at_once) else $error("output not off");

  property p_sw_clear;
    ce && io_refresh && sw_rst[0] |=> counter_clear[0] && (!sw_rst[0] || $past(reg_wr));
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("soft clear missed");

  property p_clear_gated;
    ce && !sw_en[1] && !(io_refresh && sw_rst[1]) |=> !counter_clear[1];
  endproperty
  a_clear_gated: assert property (p_clear_gated) else $error("clear not gated");

  property p_status;
    ce && reg_rd && reg_addr == hco_pkg::A_OUTSTAT |=> reg_rdata[1:0] == $past(phys);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_pulse_end;
    sh_st[0] == hco_pkg::SH_SPENT && applied[0] && ce |=> sh_st[0] == hco_pkg::SH_SPENT;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse restarted");

  c_cross: cover property (ce && cv_en[0] && cv_rise[0]);
  c_pulse: cover property (sh_st[0] == hco_pkg::SH_PULSE ##1 sh_st[0] == hco_pkg::SH_SPENT);
  c_clear: cover property (|counter_clear);
  c_manual: cover property (manual && phys[1]);
endmodule

// ### verif/hco_host_model.sv
/*
  Host controller model: issues the periodic I/O refresh pulse.
  Assumes one clock shared with the block and an active-low synchronous reset.
*/
module hco_host_model #(
  parameter int PERIOD = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Refresh strobe.
  output logic io_refresh
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 0;
      io_refresh <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      io_refresh <= (cnt == PERIOD - 1);
    end
  end
endmodule

// ### verif/counter_output_control_tb.sv
/*
  Self-checking bench for the output control block.
  Assumes the host model supplies refresh pulses; reads are checked one cycle later.
*/
module counter_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, io_refresh, bus_err = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdata, r = 32'h0000_004D;
  logic [hco_pkg::NCNT-1:0][31:0] cv = '0;
  logic [3:0] pre = 0, clr, din = 0, idx = 0;
  logic po0, po1;
  logic [31:0] expq[$];
  int fail_count = 0, num_checks = 0;
  always #25 clk = ~clk;
  hco_host_model u_hco_host_model (.clk(clk), .rst_n(rst_n), .io_refresh(io_refresh));
  hco_output_ctrl #(.TICK_CYCLES(4)) u_hco_output_ctrl (.clk(clk), .rst_n(rst_n),
    .ce(1'b1), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .counter_value(cv), .preset_evt(pre), .counter_clear(clr),
    .io_refresh(io_refresh), .host_prog_mode(1'b0), .host_bus_err(bus_err),
    .count_fault(1'b0), .digital_in(din), .index_in(idx),
    .physical_output_zero(po0), .physical_output_one(po1));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Pulses a field pin and watches the clear output for a fixed span.
  task automatic pin(input int i, input bit use_idx, input logic e);
    logic f;
    f = 1'b0;
    @(posedge clk);
    if (use_idx) idx[i] <= 1'b1;
    else din[i] <= 1'b1;
    repeat (10) begin
      @(posedge clk);
      f = f | clr[i];
    end
    idx[i] <= 1'b0;
    din[i] <= 1'b0;
    w(6);
    chk(f, e);
  endtask
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk(rdata, expq.pop_front());
  end
  initial begin
    w(20000);
    fail_count++;
    summarize();
  end
  initial begin
    logic f;
    w(20);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h0D, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    for (int i = 0; i < 40; i++) wr(8'(8'h40 + 8 * (i / 5) + i % 5), (i % 5 == 0) ? '1 >> 1 : 0);
    wr(8'h40, 32'h0000_0064);
    wr(8'h41, 32'h0000_0001);
    wr(8'h44, 32'h0000_0001);
    wr(8'h48, 32'h0000_00C8);
    wr(8'h49, 32'h0000_0003);
    wr(8'h4A, 32'h0000_0002);
    wr(8'h05, 32'h0000_0002);
    wr(8'h07, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0003);
    r = lfsr(r);
    cv[3] <= r & 32'h0FFF_FFFF;
    // Both points cross in one cycle, so the clear of point 1 must win.
    cv[0] <= 32'h0000_00FA;
    w(3);
    rd(8'h0E, 32'h0000_0001);
    rd(8'h0D, 32'h0000_0001);
    rd(8'h0F, 32'h0000_0003);
    w(20);
    rd(8'h0E, 32'h0000_0000);
    rd(8'h0D, 32'h0000_0001);
    cv[0] <= 32'h0000_0032;
    w(3);
    rd(8'h0D, 32'h0000_0000);
    rd(8'h0F, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    cv[0] <= 32'h0000_00FA;
    w(3);
    rd(8'h0D, 32'h0000_0000);
    cv[0] <= 32'h0000_0032;
    wr(8'h0A, 32'h0000_0006);
    wr(8'h0B, 32'h0000_0005);
    pre[2] <= 1'b1;
    w(1);
    pre[2] <= 1'b0;
    w(3);
    rd(8'h0D, 32'h0000_0002);
    rd(8'h0E, 32'h0000_0002);
    wr(8'h00, 32'h0000_0001);
    wr(8'h01, 32'h0000_0001);
    w(20);
    rd(8'h0E, 32'h0000_0001);
    wr(8'h00, 32'h0000_0020);
    r = lfsr(r);
    wr(8'h02, {r[31:2], 2'b00});
    bus_err <= 1'b1;
    w(4);
    rd(8'h0E, 32'h0000_0000);
    bus_err <= 1'b0;
    w(4);
    rd(8'h0E, 32'h0000_0002);
    wr(8'h03, 32'h0000_0001);
    f = 1'b0;
    repeat (40) begin
      @(posedge clk);
      f = f | clr[0];
    end
    chk(f, 1'b1);
    wr(8'h03, 32'h0002_0000);
    pin(1, 1, 1'b0);
    wr(8'h03, 32'h0002_0200);
    pin(1, 1, 1'b1);
    wr(8'h03, 32'h0000_0400);
    for (int k = 0; k < 5; k++) begin
      wr(8'h04, 32'({5'h05, 5'h06, 5'h0B, 5'h0E, 5'h07} >> (5 * (4 - k)) & 5'h1F) << 16);
      pin(2, 0, k != 4);
    end
    summarize();
  end
endmodule
